/* design/baseband_dev.sv */
/*
  device end: serial register slave, fine level and offset on both
  sample paths, coarse step outputs, free running sample counter with
  timestamps, scheduled transmit start and match interrupt.
  assumes converters and analog gain stages outside; all inputs are
  synchronous to core_clk.
*/
`timescale 1ns/100ps
module baseband_dev
  import baseband_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  baseband_if.dev                bus,
  input  wire logic              codec_mode,
  input  wire logic [15:0]       rate_div,
  input  wire logic [3:0]        interp_factor,
  input  wire logic [1:0]        rx_out_sel,
  input  wire logic              tx_en,
  input  wire logic              rx_en,
  input  wire logic [15:0]       sched_time,
  input  wire logic              sched_arm,
  input  wire logic              tx_sym_valid,
  input  wire logic [SMP_W-1:0]  tx_i,
  input  wire logic [SMP_W-1:0]  tx_q,
  output logic                   tx_sym_ready,
  output logic [SMP_W-1:0]       dac_one,
  output logic [SMP_W-1:0]       dac_two,
  output logic [TX_CS_W-1:0]     coarse_one,
  output logic [TX_CS_W-1:0]     coarse_two,
  output logic [11:0]            in_gain,
  output logic                   tx_active,
  input  wire logic [SMP_W-1:0]  adc_one,
  input  wire logic [SMP_W-1:0]  adc_two,
  output logic                   rx_valid,
  output logic [SMP_W-1:0]       rx_i,
  output logic [SMP_W-1:0]       rx_q,
  output logic [SMP_W-1:0]       rx_amp,
  output logic [2:0]             rx_phase,
  output logic [15:0]            rx_stamp,
  output logic                   rx_codec_filter_en,
  output logic                   sample_tick
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // fine gain with -6dB floor, then offset add or subtract, saturated
  function automatic logic [SMP_W-1:0] fine_level(
    input logic [SMP_W-1:0] smp,
    input logic [15:0]      setting,
    input logic             subtract
  );
    logic signed [7:0]  g;
    logic signed [24:0] prod;
    logic signed [24:0] off;
    logic signed [24:0] sum;
    g = signed'(setting[GAIN_MSB:GAIN_LSB]);
    if (!g[7] && g < FINE_MIN_POS) begin
      g = FINE_MIN_POS;
    end
    if (g[7] && g > FINE_MIN_NEG) begin
      g = FINE_MIN_NEG;
    end
    prod = 25'(signed'(smp) * g) >>> GAIN_FRAC; // sign flips data
    off = 25'(signed'(setting[OFF_MSB:OFF_LSB])) <<< OFFSET_SHIFT;
    sum = subtract ? prod - off : prod + off;
    if (sum > 25'sd32767) begin
      fine_level = 16'h7fff;
    end else if (sum < -25'sd32768) begin
      fine_level = 16'h8000;
    end else begin
      fine_level = sum[SMP_W-1:0];
    end
  endfunction

  // absolute value of a signed sample
  function automatic logic [SMP_W-1:0] mag(input logic [SMP_W-1:0] v);
    mag = v[SMP_W-1] ? 16'(-v) : v;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // serial register slave

  logic        sclk_prev_reg;
  logic [4:0]  bit_cnt_reg;
  logic [23:0] sh_in_reg;
  logic [15:0] sh_out_reg;
  logic        sclk_rise;
  logic        wr_strobe;
  logic [7:0]  wr_addr;
  logic [15:0] wr_data;
  logic [7:0]  rd_addr;
  logic [15:0] rd_data;

  assign sclk_rise = bus.sclk && !sclk_prev_reg && !bus.csn_n;
  assign wr_strobe = sclk_rise && bit_cnt_reg == 5'(FRAME_BITS - 1);
  assign wr_addr = sh_in_reg[22:15];
  assign wr_data = {sh_in_reg[14:0], bus.mosi};
  assign rd_addr = {sh_in_reg[6:0], bus.mosi};
  assign bus.miso = sh_out_reg[15];

  // frame shifting; read data loaded after the address byte
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sclk_prev_reg <= 1'b0;
      bit_cnt_reg <= 5'h00;
      sh_in_reg <= 24'h000000;
      sh_out_reg <= 16'h0000;
    end else begin
      sclk_prev_reg <= bus.sclk;
      if (bus.csn_n) begin
        bit_cnt_reg <= 5'h00;
      end else if (sclk_rise) begin
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
        sh_in_reg <= {sh_in_reg[22:0], bus.mosi};
        if (bit_cnt_reg == 5'(ADDR_W - 1)) begin
          sh_out_reg <= rd_data;
        end else begin
          sh_out_reg <= {sh_out_reg[14:0], 1'b0};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // write-only setting registers

  logic [15:0] dac_one_reg;
  logic [15:0] dac_two_reg;
  logic [15:0] adc_one_reg;
  logic [15:0] adc_two_reg;
  logic [15:0] match_reg;
  logic [15:0] input_set_reg;
  logic [15:0] out_one_cs_reg;
  logic [15:0] out_two_cs_reg;

  // register writes; unmapped addresses are ignored
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      dac_one_reg <= FINE_RESET;
      dac_two_reg <= FINE_RESET;
      adc_one_reg <= FINE_RESET;
      adc_two_reg <= FINE_RESET;
      match_reg <= REG_RESET;
      input_set_reg <= REG_RESET;
      out_one_cs_reg <= REG_RESET;
      out_two_cs_reg <= REG_RESET;
    end else if (wr_strobe) begin
      case (wr_addr)
        ADDR_DAC_ONE: begin
          dac_one_reg <= wr_data;
        end
        ADDR_DAC_TWO: begin
          dac_two_reg <= wr_data;
        end
        ADDR_ADC_ONE: begin
          adc_one_reg <= wr_data;
        end
        ADDR_ADC_TWO: begin
          adc_two_reg <= wr_data;
        end
        ADDR_MATCH: begin
          match_reg <= wr_data;
        end
        ADDR_INPUT_SET: begin
          input_set_reg <= wr_data;
        end
        ADDR_OUT_ONE_CS: begin
          out_one_cs_reg <= wr_data;
        end
        ADDR_OUT_TWO_CS: begin
          out_two_cs_reg <= wr_data;
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sample rate divider and counter

  logic [15:0] div_cnt_reg;
  logic [15:0] div_eff;
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic        irq_reg;

  // least divider per mode keeps the sample rate in range
  always_comb begin
    div_eff = rate_div;
    if (codec_mode && rate_div < DIV_MIN_CODEC) begin
      div_eff = DIV_MIN_CODEC;
    end
    if (!codec_mode && rate_div < DIV_MIN_MODEM) begin
      div_eff = DIV_MIN_MODEM;
    end
  end

  assign sample_tick = div_cnt_reg == 16'h0000;
  assign count_next = count_reg + 16'h0001; // natural wrap
  assign rd_data = (rd_addr == ADDR_COUNT) ? count_reg : 16'h0000;
  assign bus.irq = irq_reg;

  // divider and counter run regardless of converter enables
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      div_cnt_reg <= 16'h0000;
      count_reg <= 16'h0000;
    end else begin
      div_cnt_reg <= sample_tick ? div_eff - 16'h0001
                                 : div_cnt_reg - 16'h0001;
      if (sample_tick) begin
        count_reg <= count_next;
      end
    end
  end

  // match interrupt; a new match beats the clearing write
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irq_reg <= 1'b0;
    end else if (sample_tick && count_next == match_reg) begin
      irq_reg <= 1'b1;
    end else if (wr_strobe && wr_addr == ADDR_MATCH) begin
      irq_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // coarse gain outputs

  // tx codes clamp to the +6dB top step
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      coarse_one <= '0;
      coarse_two <= '0;
      in_gain <= '0;
    end else begin
      coarse_one <= (out_one_cs_reg[3:0] > TX_CS_TOP) ? TX_CS_TOP
                                            : out_one_cs_reg[3:0];
      coarse_two <= (out_two_cs_reg[3:0] > TX_CS_TOP) ? TX_CS_TOP
                                            : out_two_cs_reg[3:0];
      for (int n = 0; n < NUM_INPUTS; n++) begin
        in_gain[n*RX_CS_W +: RX_CS_W] <=
          input_set_reg[n*RX_CS_STRIDE +: RX_CS_W]; // unsigned codes
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmit path

  logic [3:0] interp_eff;
  logic [3:0] phase_reg;

  assign interp_eff = (interp_factor < INTERP_MIN) ? INTERP_MIN :
                      (interp_factor > INTERP_MAX) ? INTERP_MAX :
                      interp_factor;
  // codec takes a sample every tick, modem one symbol per interp ticks
  assign tx_sym_ready = tx_active && sample_tick &&
                        (codec_mode || phase_reg == 4'h0);

  // scheduled start at the armed count, stop when tx disabled
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tx_active <= 1'b0;
    end else if (!tx_en) begin
      tx_active <= 1'b0;
    end else if (sched_arm && sample_tick && count_next == sched_time) begin
      tx_active <= 1'b1;
    end
  end

  // symbol hold and fine level ahead of the dacs
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      phase_reg <= 4'h0;
      dac_one <= '0;
      dac_two <= '0;
    end else begin
      if (!tx_active) begin
        phase_reg <= 4'h0;
      end else if (sample_tick) begin
        phase_reg <= (phase_reg == interp_eff - 4'h1) ? 4'h0
                                                      : phase_reg + 4'h1;
      end
      if (tx_sym_ready && tx_sym_valid) begin
        dac_one <= fine_level(tx_i, dac_one_reg, 1'b0);
        dac_two <= fine_level(tx_q, dac_two_reg, 1'b0);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receive path

  logic [SMP_W-1:0] lvl_i;
  logic [SMP_W-1:0] lvl_q;
  logic [SMP_W-1:0] abs_i;
  logic [SMP_W-1:0] abs_q;
  logic [16:0]      amp_sum;

  assign lvl_i = fine_level(adc_one, adc_one_reg, 1'b1);
  assign lvl_q = fine_level(adc_two, adc_two_reg, 1'b1);
  assign abs_i = mag(lvl_i);
  assign abs_q = mag(lvl_q);
  // max plus half of min approximates the magnitude
  assign amp_sum = (abs_i > abs_q) ? {1'b0, abs_i} + {2'b00, abs_q[15:1]}
                                   : {1'b0, abs_q} + {2'b00, abs_i[15:1]};
  assign rx_codec_filter_en = codec_mode;

  // one output per tick, stamped with the running count
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rx_valid <= 1'b0;
      rx_i <= '0;
      rx_q <= '0;
      rx_amp <= '0;
      rx_phase <= 3'h0;
      rx_stamp <= 16'h0000;
    end else begin
      rx_valid <= rx_en && sample_tick;
      if (rx_en && sample_tick) begin
        rx_stamp <= count_reg;
        if (rx_out_sel != RX_OUT_POLAR) begin
          rx_i <= lvl_i;
          rx_q <= lvl_q;
        end
        if (!codec_mode && rx_out_sel != RX_OUT_RAW) begin
          rx_amp <= amp_sum[16] ? 16'hffff : amp_sum[15:0];
          rx_phase <= {lvl_i[15], lvl_q[15], abs_q > abs_i};
        end
      end
    end
  end

endmodule

/* design/baseband_host.sv */
/*
  host end: turns register commands into serial frames, returns read
  data, checks the filter selection entry and picks coefficient blocks.
  assumes the device samples mosi on the rising serial clock.
*/
`timescale 1ns/100ps
module baseband_host
  import baseband_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  baseband_if.host           bus,
  input  wire logic          cmd_valid,
  input  wire logic [7:0]    cmd_addr,
  input  wire logic [15:0]   cmd_wdata,
  output logic               cmd_ready,
  output logic               rsp_valid,
  output logic [15:0]        rsp_rdata,
  output logic               irq,
  input  wire logic          codec_mode,
  input  wire logic [15:0]   filt_sel_value,
  output logic               filt_sel_legal,
  input  wire logic          coef_is_tx,
  output logic [3:0]         coef_block
);

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01,
    ST_DONE  = 2'b11
  } host_state_t;

  host_state_t state_reg;
  logic [23:0] frame_reg;
  logic [15:0] rd_sh_reg;
  logic [4:0]  bit_cnt_reg;
  logic [3:0]  half_cnt_reg;
  logic        sclk_reg;
  logic        half_tick;

  assign cmd_ready = state_reg == ST_IDLE;
  assign half_tick = half_cnt_reg == 4'(SCLK_HALF - 1);
  assign bus.csn_n = state_reg != ST_SHIFT;
  assign bus.sclk = sclk_reg;
  assign bus.mosi = frame_reg[23];
  assign irq = bus.irq;

  ////////////////////////////////////////////////////////////////////////
  // frame sequencer: raise samples miso, fall moves to next bit
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      frame_reg <= 24'h000000;
      rd_sh_reg <= 16'h0000;
      bit_cnt_reg <= 5'h00;
      half_cnt_reg <= 4'h0;
      sclk_reg <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= 16'h0000;
    end else begin
      rsp_valid <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          half_cnt_reg <= 4'h0;
          bit_cnt_reg <= 5'h00;
          if (cmd_valid) begin
            frame_reg <= {cmd_addr, cmd_wdata};
            state_reg <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          half_cnt_reg <= half_tick ? 4'h0 : half_cnt_reg + 4'h1;
          if (half_tick && !sclk_reg) begin
            sclk_reg <= 1'b1;
            rd_sh_reg <= {rd_sh_reg[14:0], bus.miso};
          end else if (half_tick) begin
            sclk_reg <= 1'b0;
            frame_reg <= {frame_reg[22:0], 1'b0};
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            if (bit_cnt_reg == 5'(FRAME_BITS - 1)) begin
              state_reg <= ST_DONE;
            end
          end
        end
        ST_DONE: begin
          rsp_valid <= 1'b1;
          rsp_rdata <= rd_sh_reg;
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // filter entry check and coefficient block choice
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      filt_sel_legal <= 1'b0;
      coef_block <= PROG_BLOCK_RX_COEF;
    end else begin
      filt_sel_legal <= !codec_mode || filt_sel_value == FILT_SEL_CODEC ||
                        filt_sel_value == FILT_SEL_USER;
      coef_block <= coef_is_tx ? PROG_BLOCK_TX_COEF
                               : PROG_BLOCK_RX_COEF;
    end
  end

endmodule

/* design/baseband_if.sv */
/*
  serial register link between host and device, plus interrupt line.
  assumes both ends share core_clk; all pins are plain one-way wires.
*/
`timescale 1ns/100ps
interface baseband_if;
  logic csn_n;
  logic sclk;
  logic mosi;
  logic miso;
  logic irq;
  modport dev  (input csn_n, input sclk, input mosi,
                output miso, output irq);
  modport host (output csn_n, output sclk, output mosi,
                input miso, input irq);
endinterface

/* design/baseband_pkg.sv */
/*
  constants shared by both ends of the baseband level and sample sync
  link: register map, field layout, limits and rates.
  assumes a single 40 MHz core clock on both ends.
*/
package baseband_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int ADDR_W = 8;
  localparam int REG_W = 16;
  localparam int FRAME_BITS = 24;
  localparam int SMP_W = 16;

  // register map
  localparam logic [7:0] ADDR_DAC_ONE    = 8'h5d;
  localparam logic [7:0] ADDR_DAC_TWO    = 8'h5e;
  localparam logic [7:0] ADDR_ADC_ONE    = 8'h5f;
  localparam logic [7:0] ADDR_ADC_TWO    = 8'h60;
  localparam logic [7:0] ADDR_MATCH      = 8'h65;
  localparam logic [7:0] ADDR_COUNT      = 8'h7d;
  localparam logic [7:0] ADDR_INPUT_SET  = 8'hb0;
  localparam logic [7:0] ADDR_OUT_ONE_CS = 8'hb4;
  localparam logic [7:0] ADDR_OUT_TWO_CS = 8'hb5;
  localparam logic [15:0] REG_RESET      = 16'h0000;
  localparam logic [15:0] FINE_RESET     = 16'h7f00;

  // fine level field: signed gain q1.7 high byte, signed offset low byte
  localparam int GAIN_MSB = 15;
  localparam int GAIN_LSB = 8;
  localparam int OFF_MSB = 7;
  localparam int OFF_LSB = 0;
  localparam int GAIN_FRAC = 7;
  localparam int OFFSET_SHIFT = 6;
  localparam logic signed [7:0] FINE_MIN_POS = 8'sh40;
  localparam logic signed [7:0] FINE_MIN_NEG = -8'sh40;

  // coarse steps: tx 0 = -14.2 dB .. 10 = +6 dB, rx 0 = 0 dB .. 7 = +22.4 dB
  localparam int TX_CS_W = 4;
  localparam logic [3:0] TX_CS_TOP = 4'ha;
  localparam int RX_CS_W = 3;
  localparam int RX_CS_STRIDE = 4;
  localparam int NUM_INPUTS = 4;

  // sample rates and derived least divider (least period rounds up)
  localparam int DEFAULT_RATE_HZ = 48_000;
  localparam int CODEC_MAX_RATE_HZ = 72_000;
  localparam int MODEM_MAX_RATE_HZ = 144_000;
  localparam logic [15:0] DIV_DEFAULT = 16'(CLK_HZ / DEFAULT_RATE_HZ);
  localparam logic [15:0] DIV_MIN_CODEC =
    16'((CLK_HZ + CODEC_MAX_RATE_HZ - 1) / CODEC_MAX_RATE_HZ);
  localparam logic [15:0] DIV_MIN_MODEM =
    16'((CLK_HZ + MODEM_MAX_RATE_HZ - 1) / MODEM_MAX_RATE_HZ);

  // modem interpolation limits
  localparam logic [3:0] INTERP_MIN = 4'h4;
  localparam logic [3:0] INTERP_MAX = 4'ha;

  // receive output selection
  localparam logic [1:0] RX_OUT_RAW   = 2'h0;
  localparam logic [1:0] RX_OUT_POLAR = 2'h1;
  localparam logic [1:0] RX_OUT_BOTH  = 2'h2;

  // host-side filter selection and coefficient program blocks
  localparam logic [15:0] FILT_SEL_CODEC = 16'h0102;
  localparam logic [15:0] FILT_SEL_USER  = 16'h0802;
  localparam logic [3:0] PROG_BLOCK_RX_COEF = 4'h8;
  localparam logic [3:0] PROG_BLOCK_TX_COEF = 4'h9;

  // serial clock half period in core clocks
  localparam int SCLK_HALF = 4;
endpackage

/* tb/baseband_link_assertions.sv */
/*
  checker for the serial link that joins the host and device ends.
  assumes it sits beside the interface and sees its plain signals.
*/
`timescale 1ns/100ps
module baseband_link_assertions
  import baseband_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic csn_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  input wire logic irq
);
  logic [4:0]  rise_cnt;
  logic [23:0] frame_sh;
  logic        sclk_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////
  // counts serial clock rises and collects the frame in progress
  always_ff @(posedge core_clk) begin
    sclk_q <= sclk;
    if (!rst_n || csn_n) begin
      rise_cnt <= 5'h00;
    end else if (sclk && !sclk_q) begin
      rise_cnt <= rise_cnt + 5'h01;
      frame_sh <= {frame_sh[22:0], mosi};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // framing and serial clock shape
  frame_bits_a: assert property (
    $rose(csn_n) |-> rise_cnt == 5'h18)
    else $error("frame did not carry 24 clock rises");
  idle_clock_a: assert property (
    csn_n |-> !sclk)
    else $error("serial clock moved outside a frame");
  first_edge_a: assert property (
    $fell(csn_n) |-> !sclk [*4] ##1 sclk)
    else $error("first clock rise not four cycles after select");
  sclk_high_a: assert property (
    $rose(sclk) |-> sclk [*4] ##1 !sclk)
    else $error("serial clock high phase wrong");
  sclk_low_a: assert property (
    $fell(sclk) |-> !sclk [*4])
    else $error("serial clock low phase too short");
  mosi_hold_a: assert property (
    sclk && $past(sclk) |-> $stable(mosi))
    else $error("data changed while serial clock high");
  csn_hold_a: assert property (
    $fell(csn_n) |-> !csn_n [*8])
    else $error("frame select released early");

  ////////////////////////////////////////////////////////////////////////
  // the interrupt only drops on a write to the match register
  irq_clear_a: assert property (
    $fell(irq) && $past(rst_n) |->
      rise_cnt == 5'h18 && frame_sh[23:16] == ADDR_MATCH)
    else $error("interrupt dropped without a match write");
endmodule

/* tb/test_baseband_level_and_sample_sync.sv */
/*
  testbench: host and device ends joined by the link interface, worked
  through host register commands and the device sample ports.
  assumes the package constants and a 40 MHz core clock.
*/
`timescale 1ns/100ps
module test_baseband_level_and_sample_sync
  import baseband_pkg::*;
;
  localparam logic [15:0] DIV = 16'h0258;
  logic              core_clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              cmd_valid = 1'b0;
  logic [7:0]        cmd_addr = 8'h00;
  logic [15:0]       cmd_wdata = 16'h0000;
  logic              codec_mode = 1'b1;
  logic              coef_is_tx = 1'b0;
  logic [15:0]       filt_sel_value = 16'h0000;
  logic [15:0]       rate_div = DIV;
  logic [3:0]        interp_factor = 4'h4;
  logic [1:0]        rx_out_sel = RX_OUT_RAW;
  logic              tx_en = 1'b0;
  logic              rx_en = 1'b0;
  logic              sched_arm = 1'b0;
  logic              tx_sym_valid = 1'b0;
  logic [15:0]       sched_time = 16'h0000;
  logic [SMP_W-1:0]  tx_i = 16'h1000;
  logic [SMP_W-1:0]  tx_q = 16'h1000;
  logic [SMP_W-1:0]  adc_one = 16'h1000;
  logic [SMP_W-1:0]  adc_two = 16'h1000;
  logic              cmd_ready, rsp_valid, irq, filt_sel_legal;
  logic              tx_sym_ready, tx_active, rx_valid;
  logic              rx_codec_filter_en, sample_tick;
  logic [15:0]       rsp_rdata, rx_stamp, r1, r2;
  logic [SMP_W-1:0]  dac_one, dac_two, rx_i, rx_q, rx_amp;
  logic [3:0]        coef_block, coarse_one, coarse_two;
  logic [11:0]       in_gain;
  logic [2:0]        rx_phase;
  logic [15:0]       sel_tab [3] = '{FILT_SEL_CODEC, FILT_SEL_USER, 16'h0202};
  int                error_cnt = 0;
  int                check_count = 0;
  int                cyc = 0;
  int                issue, n, k;

  baseband_if baseband_if_i ();
  baseband_dev baseband_dev_i (.core_clk, .rst_n, .bus(baseband_if_i.dev),
    .codec_mode, .rate_div, .interp_factor, .rx_out_sel, .tx_en, .rx_en,
    .sched_time, .sched_arm, .tx_sym_valid, .tx_i, .tx_q, .tx_sym_ready,
    .dac_one, .dac_two, .coarse_one, .coarse_two, .in_gain, .tx_active,
    .adc_one, .adc_two, .rx_valid, .rx_i, .rx_q, .rx_amp, .rx_phase,
    .rx_stamp, .rx_codec_filter_en, .sample_tick);
  baseband_host baseband_host_i (.core_clk, .rst_n,
    .bus(baseband_if_i.host), .cmd_valid, .cmd_addr, .cmd_wdata, .cmd_ready,
    .rsp_valid, .rsp_rdata, .irq, .codec_mode, .filt_sel_value,
    .filt_sel_legal, .coef_is_tx, .coef_block);
  baseband_link_assertions baseband_link_assertions_i (.core_clk, .rst_n,
    .csn_n(baseband_if_i.csn_n), .sclk(baseband_if_i.sclk),
    .mosi(baseband_if_i.mosi), .miso(baseband_if_i.miso),
    .irq(baseband_if_i.irq));

  ////////////////////////////////////////////////////////////////////////
  // clock and cycle count
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;

  ////////////////////////////////////////////////////////////////////////
  // compare, bus and closing tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  // one host command: hold it until taken, then wait for the answer
  task automatic xfer(input logic [7:0] a, input logic [15:0] d,
                      output logic [15:0] r);
    int w;
    @(posedge core_clk);
    issue = cyc;
    cmd_valid <= 1'b1;
    cmd_addr <= a;
    cmd_wdata <= d;
    w = 0;
    do @(posedge core_clk); while (cmd_ready !== 1'b1 && ++w < 400);
    cmd_valid <= 1'b0;
    w = 0;
    do @(posedge core_clk); while (rsp_valid !== 1'b1 && ++w < 400);
    chk_flag(rsp_valid, 1'b1);
    r = rsp_rdata;
  endtask

  task automatic print_verdict;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    xfer(ADDR_OUT_ONE_CS, 16'h000f, r1);
    xfer(ADDR_OUT_TWO_CS, 16'h0003, r1);
    xfer(ADDR_INPUT_SET, 16'h7531, r1);
    chk(16'(coarse_one), 16'h000a);
    chk(16'(coarse_two), 16'h0003);
    chk(16'(in_gain), 16'h0f59);
    xfer(ADDR_OUT_ONE_CS, 16'h0000, r1);
    chk(r1, 16'h0000);
    // counter advances with the converters idle
    xfer(ADDR_COUNT, 16'h0000, r1);
    k = issue;
    while (cyc < k + 3 * int'(DIV) - 1) @(posedge core_clk);
    xfer(ADDR_COUNT, 16'h0000, r2);
    chk(r2 - r1, 16'h0003);
    // match interrupt raised, then cleared
    xfer(ADDR_MATCH, r2 + 16'h0003, r1);
    chk_flag(irq, 1'b0);
    n = 0;
    do @(posedge core_clk); while (irq !== 1'b1 && ++n < 3000);
    chk_flag(irq, 1'b1);
    xfer(ADDR_MATCH, r2 + 16'h8000, r1);
    chk_flag(irq, 1'b0);
    // fine levels, then a scheduled start with stamped samples
    xfer(ADDR_DAC_ONE, 16'hc010, r1);
    xfer(ADDR_DAC_TWO, 16'h10f0, r1);
    xfer(ADDR_ADC_ONE, 16'hc010, r1);
    xfer(ADDR_ADC_TWO, 16'h40f0, r1);
    xfer(ADDR_COUNT, 16'h0000, r1);
    @(posedge core_clk);
    sched_time <= r1 + 16'h0003;
    sched_arm <= 1'b1;
    tx_en <= 1'b1;
    rx_en <= 1'b1;
    tx_sym_valid <= 1'b1;
    n = 0;
    do @(posedge core_clk); while (tx_active !== 1'b1 && ++n < 3000);
    chk_flag(rx_valid, 1'b1);
    chk(rx_stamp, r1 + 16'h0002);
    chk(rx_i, 16'hf400);
    chk(rx_q, 16'h0c00);
    repeat (2 * DIV) @(posedge core_clk);
    chk(dac_one, 16'hfc00);
    chk(dac_two, 16'h0400);
    // modem mode: polar receive output and symbol interpolation
    codec_mode <= 1'b0;
    rx_out_sel <= RX_OUT_BOTH;
    n = 0;
    do @(posedge core_clk); while (rx_valid !== 1'b1 && ++n < 2000);
    chk(rx_amp, 16'h1200);
    chk(16'(rx_phase), 16'h0004);
    // polar only: raw outputs hold, amplitude follows the new input
    rx_out_sel <= RX_OUT_POLAR;
    adc_one <= 16'h2000;
    n = 0;
    do @(posedge core_clk); while (rx_valid !== 1'b1 && ++n < 2000);
    chk(rx_i, 16'hf400);
    chk(rx_amp, 16'h1a00);
    n = 0;
    repeat (8 * DIV) begin
      @(posedge core_clk);
      if (tx_sym_ready === 1'b1) n++;
    end
    chk(16'(n), 16'h0002);
    // least sample period in each mode, and the codec filter enable
    for (k = 0; k < 2; k++) begin
      codec_mode <= k[0];
      rate_div <= 16'h0064;
      repeat (2) begin
        n = 0;
        do @(posedge core_clk); while (sample_tick !== 1'b1 && ++n < 2000);
      end
      // the closing tick edge counts too, so start at one
      n = 1;
      do @(posedge core_clk); while (sample_tick !== 1'b1 && ++n < 2000);
      chk(16'(n), k[0] ? DIV_MIN_CODEC : DIV_MIN_MODEM);
      chk_flag(rx_codec_filter_en, k[0]);
    end
    // host filter entry check and coefficient block choice
    for (k = 0; k < 3; k++) begin
      filt_sel_value <= sel_tab[k];
      coef_is_tx <= k[0];
      repeat (3) @(posedge core_clk);
      chk_flag(filt_sel_legal, k < 2);
      chk(16'(coef_block), k[0] ? 16'h0009 : 16'h0008);
    end
    print_verdict;
  end

  // watchdog against a hang
  initial begin
    repeat (60000) @(posedge core_clk);
    error_cnt++;
    print_verdict;
  end
endmodule
